// ===== core/psfm_core.sv
// power sequencer and fault monitor: start-up order, shutdown and fault flags
// assumes power-good, fault and measurement inputs are synchronous to clk
// How it works
// - power request high enables core supplies
// - sequencer waits for both core regulators
// - three 5.5 V regulators before any buck
// - controller bucks, then mirror-array LDOs
// - reset output high once supplies are up
// - general buck by command, only after reset
// - mirror-array regulator starts as last step
// - fault type recorded in status register 0x0C
// - interrupt asserted on any monitored fault
// - register 0x0D selects which conditions count
// - supply, illumination, mirror, request flags
// - low-input warning; undervoltage forces shutdown
// - 5-bit thresholds at 0x10 and 0x11
// - overheat warning and shutdown flags reported
// - thermal shutdown level drops all rails but core supply
// - thermal flags clear only after hysteresis
module psfm_core
   import psfm_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               power_request_in,
   input  wire psfm_pgood_s        pgood,
   input  wire psfm_block_faults_s block_faults,
   input  wire logic [4:0]         vin_code,
   input  wire logic [7:0]         die_temp_c,
   input  wire logic               spi_sclk,
   input  wire logic               spi_cs_n,
   input  wire logic               spi_mosi,
   output logic                    spi_miso,
   output logic                    spi_miso_oe,
   output psfm_rails_s             rails,
   output logic                    reset_out,
   output logic                    int_n
);

   psfm_core_s  s_q;
   psfm_core_s  s_d;
   psfm_req_s   req;
   logic [7:0]  rdata;
   logic [7:0]  set_bits;
   logic [7:0]  clr_bits;
   logic        uv_now;
   logic        low_vin_now;
   logic        shut_now;

   // measured input below a programmed threshold code
   function automatic logic below(input logic [4:0] code, input logic [4:0] thr);
      below = (code < thr);
   endfunction

   // every sequenced rail off, core supply left to the request pin
   function automatic psfm_rails_s rails_down(input logic core_on);
      rails_down             = '0;
      rails_down.core_supply = core_on;
   endfunction

   psfm_spi_slave u_spi (
      .clk     (clk),
      .rst     (rst),
      .sclk    (spi_sclk),
      .cs_n    (spi_cs_n),
      .mosi    (spi_mosi),
      .rdata   (rdata),
      .miso    (spi_miso),
      .miso_oe (spi_miso_oe),
      .req     (req)
   );

   // read mux; unmapped addresses read as zero
   always_comb begin
      case (req.addr)
         ADDR_FAULT_STATUS: rdata = s_q.status;
         ADDR_FAULT_CONFIG: rdata = s_q.config_bits;
         ADDR_LOW_VIN_WARN: rdata = {3'h0, s_q.warn_thr};
         ADDR_UV_SHUTDOWN:  rdata = {3'h0, s_q.uv_thr};
         ADDR_SUPPLY_CTRL:  rdata = {3'h0, s_q.state, s_q.gp_req};
         default:           rdata = 8'h00;
      endcase
   end

   // comparators on the live measurements
   assign uv_now      = below(vin_code, s_q.uv_thr);
   assign low_vin_now = below(vin_code, s_q.warn_thr);

   always_comb begin
      s_d = s_q;

      // thermal trip levels with hysteresis on the way down
      if (die_temp_c >= TEMP_WARN_SET) begin
         s_d.warn_hot = 1'b1;
      end else if (die_temp_c < TEMP_WARN_CLR) begin
         s_d.warn_hot = 1'b0;
      end
      if (die_temp_c >= TEMP_SHUT_SET) begin
         s_d.shut_hot = 1'b1;
      end else if (die_temp_c < TEMP_SHUT_CLR) begin
         s_d.shut_hot = 1'b0;
      end
      // shutdown uses the same-cycle trip so a hot die is never a cycle late
      shut_now = uv_now | s_d.shut_hot;

      // fault events, gated by the configuration mask
      set_bits                    = '0;
      set_bits[FLT_SUPPLY]        = block_faults.supply;
      set_bits[FLT_ILLUM]         = block_faults.illum;
      set_bits[FLT_MIRROR_BLOCK]  = block_faults.mirror_block;
      set_bits[FLT_POWER_REQUEST] = power_request_in & ~s_q.req_prev;
      set_bits[FLT_LOW_VIN_WARN]  = low_vin_now;
      set_bits[FLT_UV_SHUTDOWN]   = uv_now;
      set_bits[FLT_OVERHEAT_WARN] = s_d.warn_hot;
      set_bits[FLT_THERMAL_SHUT]  = s_d.shut_hot;
      set_bits                    = set_bits & s_q.config_bits;
      s_d.req_prev                = power_request_in;

      // clear on read; a new event in the same cycle still lands
      clr_bits = (req.rd && req.addr == ADDR_FAULT_STATUS) ? 8'hff : 8'h00;
      s_d.status = (s_q.status & ~clr_bits) | set_bits;

      // register writes; fault_status is read-only
      if (req.wr) begin
         case (req.addr)
            ADDR_FAULT_CONFIG: s_d.config_bits = req.wdata;
            ADDR_LOW_VIN_WARN: s_d.warn_thr    = req.wdata[4:0];
            ADDR_UV_SHUTDOWN:  s_d.uv_thr      = req.wdata[4:0];
            ADDR_SUPPLY_CTRL:  s_d.gp_req      = req.wdata[CTRL_GP_BUCK];
            default: ;
         endcase
      end

      // start-up sequencer; loss of request or a shutdown fault overrides it
      if (!power_request_in) begin
         s_d.state     = ST_OFF;
         s_d.rails     = rails_down(1'b0);
         s_d.reset_out = 1'b0;
      end else if (shut_now) begin
         s_d.state     = ST_SHUTDOWN;
         s_d.rails     = rails_down(1'b1);
         s_d.reset_out = 1'b0;
      end else begin
         case (s_q.state)
            ST_OFF: begin
               s_d.rails.core_supply = 1'b1;
               s_d.state             = ST_CORE_UP;
            end
            ST_CORE_UP: begin
               if (pgood.core_2v5_supply && pgood.core_5v_supply) begin
                  s_d.rails.main_5v5_regulator         = 1'b1;
                  s_d.rails.reset_driver_5v5_regulator = 1'b1;
                  s_d.rails.illumination_5v5_regulator = 1'b1;
                  s_d.state                            = ST_AUX_UP;
               end
            end
            ST_AUX_UP: begin
               if (&pgood.aux_5v5) begin
                  s_d.rails.controller_buck_a = 1'b1;
                  s_d.rails.controller_buck_b = 1'b1;
                  s_d.state                   = ST_BUCK_UP;
               end
            end
            ST_BUCK_UP: begin
               if (&pgood.buck) begin
                  s_d.rails.mirror_ldo_a = 1'b1;
                  s_d.rails.mirror_ldo_b = 1'b1;
                  s_d.state              = ST_LDO_UP;
               end
            end
            ST_LDO_UP: begin
               if (&pgood.ldo) begin
                  s_d.reset_out = 1'b1;
                  s_d.state     = ST_MIRROR_UP;
               end
            end
            ST_MIRROR_UP: begin
               s_d.rails.mirror_regulator = 1'b1;
               s_d.state                  = ST_RUN;
            end
            ST_RUN: begin
               s_d.state = ST_RUN;
            end
            ST_SHUTDOWN: begin
               s_d.state = ST_OFF;      // fault gone: run the start-up again
            end
            default: begin
               s_d.state     = ST_OFF;
               s_d.rails     = rails_down(1'b0);
               s_d.reset_out = 1'b0;
            end
         endcase
      end

      // the general buck follows its command only while reset is released
      s_d.rails.general_purpose_buck = s_d.gp_req & s_d.reset_out;

      // level interrupt, active low, while any enabled flag stands
      s_d.int_n = ~|(s_d.status & s_d.config_bits);
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q             <= '0;
         s_q.state       <= ST_OFF;
         s_q.int_n       <= 1'b1;
         s_q.status      <= FAULT_STATUS_RST;
         s_q.config_bits <= FAULT_CONFIG_RST;
         s_q.warn_thr    <= WARN_THR_RST;
         s_q.uv_thr      <= UV_THR_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rails     = s_q.rails;
   assign reset_out = s_q.reset_out;
   assign int_n     = s_q.int_n;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_core_follow;
      !power_request_in |=> !rails.core_supply && !reset_out;
   endproperty
   a_core_follow: assert property (p_core_follow)
      else $error("core supply or reset left on without power request");

   property p_core_gate;
      $rose(rails.main_5v5_regulator) |-> $past(pgood.core_2v5_supply && pgood.core_5v_supply);
   endproperty
   a_core_gate: assert property (p_core_gate)
      else $error("5.5 V stage started before core regulators were good");

   property p_aux_before_buck;
      $rose(rails.controller_buck_a) |-> rails.main_5v5_regulator
         && rails.reset_driver_5v5_regulator && rails.illumination_5v5_regulator
         && $past(&pgood.aux_5v5);
   endproperty
   a_aux_before_buck: assert property (p_aux_before_buck)
      else $error("buck started before the 5.5 V regulators");

   property p_buck_before_ldo;
      $rose(rails.mirror_ldo_a) |-> rails.controller_buck_a && rails.controller_buck_b
         && $past(&pgood.buck);
   endproperty
   a_buck_before_ldo: assert property (p_buck_before_ldo)
      else $error("mirror LDO started before controller bucks were good");

   property p_reset_release;
      $rose(reset_out) |-> rails.mirror_ldo_a && rails.mirror_ldo_b && $past(&pgood.ldo)
         ##1 rails.mirror_regulator;
   endproperty
   a_reset_release: assert property (p_reset_release)
      else $error("reset released early or mirror regulator not next");

   property p_gp_after_reset;
      rails.general_purpose_buck |-> reset_out;
   endproperty
   a_gp_after_reset: assert property (p_gp_after_reset)
      else $error("general buck on while reset is low");

   property p_mirror_last;
      $rose(rails.mirror_regulator) |-> $past(reset_out);
   endproperty
   a_mirror_last: assert property (p_mirror_last)
      else $error("mirror regulator started before reset release");

   property p_hot_shutdown;
      power_request_in && die_temp_c >= TEMP_SHUT_SET |=>
         !reset_out && !rails.controller_buck_a && !rails.mirror_regulator
         && s_q.status[FLT_THERMAL_SHUT] == s_q.config_bits[FLT_THERMAL_SHUT];
   endproperty
   a_hot_shutdown: assert property (p_hot_shutdown)
      else $error("thermal shutdown did not drop rails or set its flag");

   property p_uv_shutdown;
      power_request_in && vin_code < s_q.uv_thr |=> !reset_out && !rails.main_5v5_regulator;
   endproperty
   a_uv_shutdown: assert property (p_uv_shutdown)
      else $error("undervoltage did not force shutdown");

   property p_shut_hysteresis;
      s_q.shut_hot && die_temp_c >= TEMP_SHUT_CLR |=> s_q.shut_hot;
   endproperty
   a_shut_hysteresis: assert property (p_shut_hysteresis)
      else $error("thermal shutdown released inside its hysteresis band");

   property p_int_on_fault;
      block_faults.supply && s_q.config_bits[FLT_SUPPLY] |=> !int_n [*2];
   endproperty
   a_int_on_fault: assert property (p_int_on_fault)
      else $error("enabled fault did not assert the interrupt");

   property p_sticky;
      s_q.status[FLT_ILLUM] && !(req.rd && req.addr == ADDR_FAULT_STATUS)
         |=> s_q.status[FLT_ILLUM];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("fault flag cleared without a status read");

   property p_status_record;
      block_faults.illum && s_q.config_bits[FLT_ILLUM] |=> s_q.status[FLT_ILLUM];
   endproperty
   a_status_record: assert property (p_status_record)
      else $error("enabled illumination fault not recorded in status");

   property p_mask;
      !s_q.config_bits[FLT_SUPPLY] && !s_q.status[FLT_SUPPLY] |=> !s_q.status[FLT_SUPPLY];
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked supply fault reached the status register");

   property p_request_flag;
      $rose(power_request_in) && s_q.config_bits[FLT_POWER_REQUEST]
         |=> s_q.status[FLT_POWER_REQUEST];
   endproperty
   a_request_flag: assert property (p_request_flag)
      else $error("power request rise not flagged");

   property p_threshold_write;
      req.wr && req.addr == ADDR_UV_SHUTDOWN |=> s_q.uv_thr == $past(req.wdata[4:0]);
   endproperty
   a_threshold_write: assert property (p_threshold_write)
      else $error("undervoltage threshold write not taken");

   property p_warn_flag;
      die_temp_c >= TEMP_WARN_SET && s_q.config_bits[FLT_OVERHEAT_WARN]
         |=> s_q.status[FLT_OVERHEAT_WARN];
   endproperty
   a_warn_flag: assert property (p_warn_flag)
      else $error("overheat warning not recorded in status");

   property p_shut_state;
      s_q.state == ST_SHUTDOWN |-> !reset_out && !rails.main_5v5_regulator
         && !rails.general_purpose_buck && !rails.mirror_regulator;
   endproperty
   a_shut_state: assert property (p_shut_state)
      else $error("rails or reset left on in shutdown");

   c_reach_run:  cover property (s_q.state == ST_MIRROR_UP ##1 s_q.state == ST_RUN);
   c_shutdown:   cover property (s_q.state == ST_RUN ##1 s_q.state == ST_SHUTDOWN);
   c_restart:    cover property (s_q.state == ST_SHUTDOWN ##[1:50] $rose(reset_out));
   c_gp_buck:    cover property ($rose(rails.general_purpose_buck));

endmodule

// ===== core/psfm_pkg.sv
// shared constants and carrier types for the power sequencer and fault monitor
// assumes every input is already synchronous to the 25 MHz clock
package psfm_pkg;

   // register addresses as carried in the serial command byte
   localparam logic [6:0] ADDR_FAULT_STATUS   = 7'h0c;
   localparam logic [6:0] ADDR_FAULT_CONFIG   = 7'h0d;
   localparam logic [6:0] ADDR_LOW_VIN_WARN   = 7'h10;
   localparam logic [6:0] ADDR_UV_SHUTDOWN    = 7'h11;
   localparam logic [6:0] ADDR_SUPPLY_CTRL    = 7'h12;

   // fault_status bit positions
   localparam int FLT_SUPPLY         = 0;
   localparam int FLT_ILLUM          = 1;
   localparam int FLT_MIRROR_BLOCK   = 2;
   localparam int FLT_POWER_REQUEST  = 3;
   localparam int FLT_LOW_VIN_WARN   = 4;
   localparam int FLT_UV_SHUTDOWN    = 5;
   localparam int FLT_OVERHEAT_WARN  = 6;
   localparam int FLT_THERMAL_SHUT   = 7;

   // supply_ctrl bit positions
   localparam int CTRL_GP_BUCK       = 0;
   localparam int CTRL_STATE_LSB     = 1;

   // reset values
   localparam logic [7:0] FAULT_STATUS_RST  = 8'h00;
   localparam logic [7:0] FAULT_CONFIG_RST  = 8'hff;
   localparam logic [4:0] WARN_THR_RST      = 5'h14;
   localparam logic [4:0] UV_THR_RST        = 5'h0a;

   // die temperature in degrees C, hysteresis below each trip level
   localparam logic [7:0] TEMP_WARN_SET     = 8'h78;
   localparam logic [7:0] TEMP_WARN_HYST    = 8'h0a;
   localparam logic [7:0] TEMP_SHUT_SET     = 8'h96;
   localparam logic [7:0] TEMP_SHUT_HYST    = 8'h0f;
   localparam logic [7:0] TEMP_WARN_CLR     = TEMP_WARN_SET - TEMP_WARN_HYST;
   localparam logic [7:0] TEMP_SHUT_CLR     = TEMP_SHUT_SET - TEMP_SHUT_HYST;

   // serial framing: first byte is {write, addr[6:0]}, second is data
   localparam logic [2:0] SPI_LAST_BIT      = 3'h7;
   localparam int         SPI_WR_BIT        = 7;

   typedef enum logic [3:0] {
      ST_OFF,
      ST_CORE_UP,
      ST_AUX_UP,
      ST_BUCK_UP,
      ST_LDO_UP,
      ST_MIRROR_UP,
      ST_RUN,
      ST_SHUTDOWN
   } psfm_state_e;

   typedef struct packed {
      logic       core_2v5_supply;
      logic       core_5v_supply;
      logic [2:0] aux_5v5;        // main, reset driver, illumination
      logic [1:0] buck;           // controller_buck_b, controller_buck_a
      logic [1:0] ldo;            // mirror_ldo_b, mirror_ldo_a
   } psfm_pgood_s;

   typedef struct packed {
      logic supply;
      logic illum;
      logic mirror_block;
   } psfm_block_faults_s;

   typedef struct packed {
      logic core_supply;
      logic main_5v5_regulator;
      logic reset_driver_5v5_regulator;
      logic illumination_5v5_regulator;
      logic controller_buck_a;
      logic controller_buck_b;
      logic mirror_ldo_a;
      logic mirror_ldo_b;
      logic general_purpose_buck;
      logic mirror_regulator;
   } psfm_rails_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } psfm_req_s;

   typedef struct packed {
      logic       sclk_prev;
      logic [2:0] bitcnt;
      logic       second_byte;
      logic [7:0] rx;
      logic [7:0] cmd;
      logic [7:0] tx;
      logic       miso;
      logic       miso_oe;
      psfm_req_s  req;
   } psfm_spi_s;

   typedef struct packed {
      psfm_state_e state;
      psfm_rails_s rails;
      logic        reset_out;
      logic        int_n;
      logic [7:0]  status;
      logic [7:0]  config_bits;
      logic [4:0]  warn_thr;
      logic [4:0]  uv_thr;
      logic        gp_req;
      logic        req_prev;
      logic        warn_hot;
      logic        shut_hot;
   } psfm_core_s;

endpackage

// ===== core/psfm_spi_slave.sv
// serial register port: mode 0, msb first, two bytes per access
// assumes sclk, cs_n and mosi are synchronous and sclk is slow against clk
module psfm_spi_slave
   import psfm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       mosi,
   input  wire logic [7:0] rdata,
   output logic            miso,
   output logic            miso_oe,
   output psfm_req_s       req
);

   psfm_spi_s s_q;
   psfm_spi_s s_d;
   logic      rise;
   logic      fall;
   logic [7:0] rx_next;

   // edges are found by comparing against the last sampled level
   assign rise    = sclk & ~s_q.sclk_prev;
   assign fall    = ~sclk & s_q.sclk_prev;
   assign rx_next = {s_q.rx[6:0], mosi};

   // frame decode and shift registers
   always_comb begin
      s_d           = s_q;
      s_d.sclk_prev = sclk;
      s_d.req.wr    = 1'b0;
      s_d.req.rd    = 1'b0;
      if (cs_n) begin
         s_d.bitcnt      = '0;
         s_d.second_byte = 1'b0;
         s_d.miso_oe     = 1'b0;
         s_d.miso        = 1'b0;
      end else begin
         s_d.miso_oe = 1'b1;
         if (s_q.req.rd) begin
            s_d.tx = rdata;                 // load wins over a shift
         end else if (fall) begin
            s_d.miso = s_q.tx[7];
            s_d.tx   = {s_q.tx[6:0], 1'b0};
         end
         if (rise) begin
            s_d.rx     = rx_next;
            s_d.bitcnt = s_q.bitcnt + 3'h1;
            if (s_q.bitcnt == SPI_LAST_BIT) begin
               s_d.second_byte = ~s_q.second_byte;
               if (!s_q.second_byte) begin
                  s_d.cmd      = rx_next;
                  s_d.req.addr = rx_next[6:0];
                  s_d.req.rd   = ~rx_next[SPI_WR_BIT];
               end else begin
                  s_d.req.addr  = s_q.cmd[6:0];
                  s_d.req.wdata = rx_next;
                  s_d.req.wr    = s_q.cmd[SPI_WR_BIT];
               end
            end
         end
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign miso    = s_q.miso;
   assign miso_oe = s_q.miso_oe;
   assign req     = s_q.req;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_spi_wr_needs_frame;
      req.wr |-> $past(!cs_n);
   endproperty
   a_spi_wr_needs_frame: assert property (p_spi_wr_needs_frame)
      else $error("register write without an active frame");

   property p_oe_follows_frame;
      miso_oe == $past(!cs_n);
   endproperty
   a_oe_follows_frame: assert property (p_oe_follows_frame)
      else $error("data output enable does not follow the frame select");

   c_spi_write: cover property (req.wr);
   c_spi_read:  cover property (req.rd ##[1:100] fall);

endmodule

// ===== tb/psfm_ctrl_model.sv
// serial master standing in for the display controller on the register port
// assumes the core samples sclk on clk, so each sclk phase spans several clk
module psfm_ctrl_model
   import psfm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [15:0] frame,
   input  wire logic        miso,
   output logic             done,
   output logic [7:0]       rdata,
   output logic             sclk,
   output logic             cs_n,
   output logic             mosi
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 6; // margin over the 2 clk minimum per phase

   // one frame per request: command byte, then data byte, mode 0, msb first
   // the general buck start and other commands travel here
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      done = 1'b0;
      rdata = 8'h00;
      forever begin
         @(posedge clk iff go);
         cs_n <= 1'b0;
         for (int i = 15; i >= 0; i--) begin
            mosi <= frame[i];
            repeat (HALF) @(posedge clk);
            sclk <= 1'b1;
            if (i < 8) rdata[i] <= miso; // miso holds between falling edges
            repeat (HALF) @(posedge clk);
            sclk <= 1'b0;
         end
         repeat (HALF) @(posedge clk);
         cs_n <= 1'b1;
         mosi <= ~mosi; // a released line must not look like held data
         done <= 1'b1;
         @(posedge clk);
         done <= 1'b0;
         repeat (2) @(posedge clk); // gap with cs_n high between frames
      end
   end
endmodule

// ===== tb/tb_psfm_core.sv
// self-checking bench for the power sequencer and fault monitor core
// assumes psfm_ctrl_model drives the serial port on behalf of the bench
module tb_psfm_core
   import psfm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clk;
   logic               rst;
   logic               power_request_in;
   psfm_pgood_s        pgood;
   psfm_block_faults_s block_faults;
   logic [4:0]         vin_code;
   logic [7:0]         die_temp_c;
   logic               go;
   logic [15:0]        frame;
   logic               done;
   logic [7:0]         rdata;
   logic               sclk;
   logic               cs_n;
   logic               mosi;
   logic               miso;
   logic               miso_oe;
   psfm_rails_s        rails;
   logic               reset_out;
   logic               int_n;
   int                 err_count = 0;
   int                 total_checks = 0;
   // rows of {write, addr, wdata, expected read}
   localparam logic [23:0] REG_ROWS [14] = '{
      24'h0d00ff, 24'h100014, 24'h11000a, 24'h0c0000, 24'h8c5a00, 24'h0c0000,
      24'h200000, 24'ha07700, 24'h8d3c00, 24'h0d003c, 24'h8dff00, 24'h910b00,
      24'h11000b, 24'h910a00};

   psfm_core uut (.clk(clk), .rst(rst), .power_request_in(power_request_in),
      .pgood(pgood), .block_faults(block_faults), .vin_code(vin_code),
      .die_temp_c(die_temp_c), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .spi_miso(miso), .spi_miso_oe(miso_oe), .rails(rails), .reset_out(reset_out),
      .int_n(int_n));
   psfm_ctrl_model ctrl (.clk(clk), .go(go), .frame(frame), .miso(miso),
      .done(done), .rdata(rdata), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // go is held until the edge at which done is seen high
   task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d);
      int n;
      n = 0;
      go <= 1'b1;
      frame <= {wr, a, d};
      @(posedge clk);
      while (done !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      go <= 1'b0;
      @(posedge clk);
      if (n >= 400) begin
         err_count++;
         $display("Error %0t serial frame never finished", $time);
      end
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk({2'h0, rdata}, {2'h0, e});
   endtask

   task automatic step(input logic [8:0] pg, input logic [9:0] er, input logic eo);
      pgood <= pg;
      tick(3);
      chk(rails, er);
      chk({9'h0, reset_out}, {9'h0, eo});
   endtask

   // watchdog sized well above the roughly 6.4k cycles the tests need
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      $display("Error %0t watchdog expired", $time);
      end_of_test();
   end

   initial begin
      rst = 1'b1;
      power_request_in = 1'b0;
      pgood = '0;
      block_faults = '0;
      vin_code = 5'h1f;
      die_temp_c = 8'h19;
      go = 1'b0;
      frame = 16'h0000;
      tick(8);
      rst <= 1'b0;
      tick(2);
      chk(rails, 10'h000);
      chk({9'h0, int_n}, 10'h001);
      chk({9'h0, miso_oe}, 10'h000);
      for (int i = 0; i < 14; i++) begin
         xfer(REG_ROWS[i][23], REG_ROWS[i][22:16], REG_ROWS[i][15:8]);
         if (!REG_ROWS[i][23]) chk({2'h0, rdata}, {2'h0, REG_ROWS[i][7:0]});
      end
      xfer(1'b1, ADDR_SUPPLY_CTRL, 8'h01);
      $display("test registers done");
      // supplies come up one group at a time; general buck waits for reset
      power_request_in <= 1'b1;
      step(9'h000, 10'h200, 1'b0);
      step(9'h180, 10'h3c0, 1'b0);
      step(9'h1f0, 10'h3f0, 1'b0);
      step(9'h1fc, 10'h3fc, 1'b0);
      step(9'h1ff, 10'h3ff, 1'b1);
      rd(ADDR_SUPPLY_CTRL, 8'h0d);
      $display("test sequence done");
      chk({9'h0, int_n}, 10'h000);
      rd(ADDR_FAULT_STATUS, 8'h08);
      tick(2);
      chk({9'h0, int_n}, 10'h001);
      for (int b = 0; b < 3; b++) begin
         block_faults <= 3'b100 >> b;
         tick(1);
         block_faults <= 3'b000;
         tick(2);
         chk({9'h0, int_n}, 10'h000);
         rd(ADDR_FAULT_STATUS, 8'h01 << b);
      end
      xfer(1'b1, ADDR_FAULT_CONFIG, 8'hfe);
      block_faults <= 3'b100;
      tick(1);
      block_faults <= 3'b000;
      tick(2);
      chk({9'h0, int_n}, 10'h001);
      rd(ADDR_FAULT_STATUS, 8'h00);
      xfer(1'b1, ADDR_FAULT_CONFIG, 8'hff);
      $display("test block faults done");
      // input between the two thresholds: warning only, rails stay up
      vin_code <= 5'h0a;
      tick(3);
      chk(rails, 10'h3ff);
      rd(ADDR_FAULT_STATUS, 8'h10);
      vin_code <= 5'h09;
      step(9'h1ff, 10'h200, 1'b0);
      rd(ADDR_FAULT_STATUS, 8'h30);
      vin_code <= 5'h1f;
      tick(12);
      step(9'h1ff, 10'h3ff, 1'b1);
      rd(ADDR_FAULT_STATUS, 8'h30);
      $display("test input voltage done");
      die_temp_c <= 8'h78;
      tick(3);
      rd(ADDR_FAULT_STATUS, 8'h40);
      die_temp_c <= 8'h6e;
      tick(3);
      rd(ADDR_FAULT_STATUS, 8'h40);
      die_temp_c <= 8'h6d;
      rd(ADDR_FAULT_STATUS, 8'h40);
      rd(ADDR_FAULT_STATUS, 8'h00);
      die_temp_c <= 8'h96;
      step(9'h1ff, 10'h200, 1'b0);
      die_temp_c <= 8'h87;
      step(9'h1ff, 10'h200, 1'b0);
      rd(ADDR_FAULT_STATUS, 8'hc0);
      die_temp_c <= 8'h86;
      tick(12);
      step(9'h1ff, 10'h3ff, 1'b1);
      $display("test thermal done");
      power_request_in <= 1'b0;
      step(9'h1ff, 10'h000, 1'b0);
      $display("test request drop done");
      end_of_test();
   end
endmodule
